// ---- ext_int_defines.vh ----
`ifndef EXT_INT_DEFINES_VH
`define EXT_INT_DEFINES_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define EXT_INT_CONFIG_ADDR 8'he4
`define TIMER_CONTROL_ADDR 8'h88

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define CFG_A_SEL_LSB 0
`define CFG_A_SEL_MSB 2
`define CFG_A_POL_BIT 3
`define CFG_B_SEL_LSB 4
`define CFG_B_SEL_MSB 6
`define CFG_B_POL_BIT 7
`define CFG_RESET 8'h01

// ****************************************************************
// Timer control register fields
// ****************************************************************
`define TIMER_CONTROL_REG_A_TYPE_BIT 0
`define TIMER_CONTROL_REG_A_PEND_BIT 1
`define TIMER_CONTROL_REG_B_TYPE_BIT 2
`define TIMER_CONTROL_REG_B_PEND_BIT 3
`define TIMER_CONTROL_REG_RESET 8'h00

// ****************************************************************
// Timing counts
// ****************************************************************
`define SYNC_FILL_DONE 2'h3

`endif

// ---- ext_int_detect.v ----
`timescale 1ns/10ps
`include "ext_int_defines.vh"
// ****************************************************************
// One external interrupt channel: sync, polarity, edge or level
// ****************************************************************
module ext_int_detect
(
  input wire ref_clk_i,
  input wire rst_i,
  input wire [7:0] pins_i,
  input wire [2:0] pin_sel_i,
  input wire active_high_i,
  input wire edge_mode_i,
  input wire vector_ack_i,
  input wire sw_write_i,
  input wire sw_value_i,
  output reg pending_o
);

  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  reg active_q;
  reg [1:0] fill_q;
  wire active_now;

  // Pin selection reads only, never drives the pin
  assign active_now = sync2_q[pin_sel_i] ~^ active_high_i;

  // Two-stage synchroniser on all candidate pins
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end
    else
    begin
      sync1_q <= pins_i;
      sync2_q <= sync1_q;
    end
  end

  // Sync fill count; hides the reset value of the flops
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      fill_q <= 2'h0;
    else if (fill_q != `SYNC_FILL_DONE)
      fill_q <= fill_q + 2'h1;
  end

  // Previous active state for edge detection
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      active_q <= 1'b0;
    else
      active_q <= active_now;
  end

  // Pending flag; a new edge wins over a vector ack or a software write, but not over the sync fill clear
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pending_o <= 1'b0;
    else if (fill_q != `SYNC_FILL_DONE)
      pending_o <= 1'b0;
    else if (!edge_mode_i)
      pending_o <= active_now;
    else if (active_now && !active_q)
      pending_o <= 1'b1;
    else if (vector_ack_i)
      pending_o <= 1'b0;
    else if (sw_write_i)
      pending_o <= sw_value_i;
  end

endmodule // ext_int_detect

// ---- external_pin_interrupts.v ----
`timescale 1ns/10ps
`include "ext_int_defines.vh"

// How it works
// - A trigger-type bit per input picks edge (1) or level (0) sensing.
// - A polarity bit per input in the config register picks high (1).
// - Each input watches its chosen pin read-only, whatever the crossbar use.
// - Pending flags sit at bits 1 and 3 of the timer control register.
// - In edge mode the flag clears when the core vectors to the routine.
// - In level mode the flag follows whether the input is active.
module external_pin_interrupts
(
  input wire ref_clk_i,
  input wire rst_i,
  input wire [7:0] port0_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire vector_a_i,
  input wire vector_b_i,
  output reg [7:0] reg_rdata_o,
  output reg ext_irq_a_o,
  output reg ext_irq_b_o
);

  reg [7:0] ext_int_config_q;
  reg irq_a_trigger_type_q;
  reg irq_b_trigger_type_q;
  wire irq_a_pending;
  wire irq_b_pending;
  wire cfg_sel;
  wire timer_control_reg_sel;
  wire cfg_wr;
  wire timer_control_reg_wr;
  wire [7:0] timer_control_reg_view;
  reg [7:0] read_mux;

  // ****************************************************************
  // Address decoding
  // ****************************************************************

  // Address match shared by the write and read decoders
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Register selects from the bus address
  assign cfg_sel = addr_hit(reg_addr_i, `EXT_INT_CONFIG_ADDR);
  assign timer_control_reg_sel = addr_hit(reg_addr_i, `TIMER_CONTROL_ADDR);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  assign cfg_wr = reg_wr_i && cfg_sel;
  assign timer_control_reg_wr = reg_wr_i && timer_control_reg_sel;

  // Configuration and trigger-type bits
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_int_config_q <= `CFG_RESET;
      irq_a_trigger_type_q <= 1'b0;
      irq_b_trigger_type_q <= 1'b0;
    end
    else
    begin
      if (cfg_wr)
        ext_int_config_q <= reg_wdata_i;
      if (timer_control_reg_wr)
      begin
        irq_a_trigger_type_q <= reg_wdata_i[`TIMER_CONTROL_REG_A_TYPE_BIT];
        irq_b_trigger_type_q <= reg_wdata_i[`TIMER_CONTROL_REG_B_TYPE_BIT];
      end
    end
  end

  // ****************************************************************
  // Detection channels
  // ****************************************************************
  ext_int_detect u_chan_a
  (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pins_i(port0_i),
    .pin_sel_i(ext_int_config_q[`CFG_A_SEL_MSB:`CFG_A_SEL_LSB]),
    .active_high_i(ext_int_config_q[`CFG_A_POL_BIT]),
    .edge_mode_i(irq_a_trigger_type_q),
    .vector_ack_i(vector_a_i),
    .sw_write_i(timer_control_reg_wr),
    .sw_value_i(reg_wdata_i[`TIMER_CONTROL_REG_A_PEND_BIT]),
    .pending_o(irq_a_pending)
  );

  ext_int_detect u_chan_b
  (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pins_i(port0_i),
    .pin_sel_i(ext_int_config_q[`CFG_B_SEL_MSB:`CFG_B_SEL_LSB]),
    .active_high_i(ext_int_config_q[`CFG_B_POL_BIT]),
    .edge_mode_i(irq_b_trigger_type_q),
    .vector_ack_i(vector_b_i),
    .sw_write_i(timer_control_reg_wr),
    .sw_value_i(reg_wdata_i[`TIMER_CONTROL_REG_B_PEND_BIT]),
    .pending_o(irq_b_pending)
  );

  // Low nibble of the timer control view; other bits belong elsewhere
  assign timer_control_reg_view = {4'h0, irq_b_pending, irq_b_trigger_type_q,
                      irq_a_pending, irq_a_trigger_type_q};

  // Read multiplexer; unmapped addresses read as zero
  always @*
  begin
    if (cfg_sel)
      read_mux = ext_int_config_q;
    else if (timer_control_reg_sel)
      read_mux = timer_control_reg_view;
    else
      read_mux = 8'h00;
  end

  // ****************************************************************
  // Read data and request outputs
  // ****************************************************************
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      ext_irq_a_o <= 1'b0;
      ext_irq_b_o <= 1'b0;
    end
    else
    begin
      ext_irq_a_o <= irq_a_pending;
      ext_irq_b_o <= irq_b_pending;
      if (reg_rd_i)
        reg_rdata_o <= read_mux;
    end
  end

endmodule // external_pin_interrupts

// ---- ext_irq_source.sv ----
`timescale 1ns/10ps
module ext_irq_source
(
  input wire ref_clk_i,
  input wire [7:0] level_i,
  output reg [7:0] pins_o
);
  // Pin levels held as commanded
  initial pins_o = 8'h00;
  always @(posedge ref_clk_i)
    pins_o <= level_i;
endmodule // ext_irq_source

// ---- ext_int_properties.sv ----
`timescale 1ns/10ps
module ext_int_checker
(
  input wire ref_clk_i,
  input wire rst_i,
  input wire [7:0] port0_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire vector_a_i,
  input wire vector_b_i,
  input wire [7:0] reg_rdata_o,
  input wire ext_irq_a_o,
  input wire ext_irq_b_o
);
  reg [7:0] c_q;
  reg [1:0] t_q;
  reg [2:0] q_q;
  wire act_a = port0_i[c_q[2:0]] ~^ c_q[3];
  wire act_b = port0_i[c_q[6:4]] ~^ c_q[7];
  wire ok = q_q == 3'h7;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow config, count quiet cycles
  always @(posedge ref_clk_i or posedge rst_i)
    if (rst_i) {c_q, t_q, q_q} <= {8'h01, 2'h0, 3'h0};
    else if (reg_wr_i)
    begin
      q_q <= 3'h0;
      if (reg_addr_i == 8'he4) c_q <= reg_wdata_i;
      if (reg_addr_i == 8'h88) t_q <= {reg_wdata_i[2], reg_wdata_i[0]};
    end
    else if (!ok) q_q <= q_q + 3'h1;
  property p_la; ok && !t_q[0] |-> ext_irq_a_o == $past(act_a, 4); endproperty
  a_la: assert property (p_la) else $error("la");
  property p_lb; ok && !t_q[1] |-> ext_irq_b_o == $past(act_b, 4); endproperty
  a_lb: assert property (p_lb) else $error("lb");
  property p_ed; ok && t_q[0] && $past(act_a, 4) && !$past(act_a, 5)
    && !$past(vector_a_i) |-> ext_irq_a_o; endproperty
  a_ed: assert property (p_ed) else $error("ed");
  property p_cl; ok && t_q[0] && vector_a_i
    && $past(act_a) == $past(act_a, 2) && $past(act_a, 2) == $past(act_a, 3)
    |-> ##2 !ext_irq_a_o; endproperty
  a_cl: assert property (p_cl) else $error("cl");
  property p_ho; ok && t_q[0] && ext_irq_a_o && !vector_a_i
    && !$past(vector_a_i) |=> ext_irq_a_o; endproperty
  a_ho: assert property (p_ho) else $error("ho");
  property p_rc; reg_rd_i && !reg_wr_i && reg_addr_i == 8'he4
    |=> reg_rdata_o == $past(c_q); endproperty
  a_rc: assert property (p_rc) else $error("rc");
  property p_rt; reg_rd_i && !reg_wr_i && reg_addr_i == 8'h88 |=> reg_rdata_o
    == {4'h0, ext_irq_b_o, t_q[1], ext_irq_a_o, t_q[0]}; endproperty
  a_rt: assert property (p_rt) else $error("rt");
  property p_un; reg_rd_i && reg_addr_i != 8'he4 && reg_addr_i != 8'h88
    |=> reg_rdata_o == 8'h00; endproperty
  a_un: assert property (p_un) else $error("un");
endmodule // ext_int_checker
bind external_pin_interrupts ext_int_checker chk_u (.ref_clk_i, .rst_i,
  .port0_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .vector_a_i,
  .vector_b_i, .reg_rdata_o, .ext_irq_a_o, .ext_irq_b_o);

// ---- external_pin_interrupts_tb_top.sv ----
`timescale 1ns/10ps
module external_pin_interrupts_tb_top;
  reg ref_clk_i = 0;
  reg rst_i = 1;
  reg [7:0] ad = 0, wd = 0, lv = 0;
  reg wr = 0, rd = 0, va = 0, vb = 0;
  wire [7:0] pins, rdat;
  wire ia, ib;
  integer fail_count = 0, checked = 0, i;
  reg [17:0] rows [0:3];
  always #5 ref_clk_i = ~ref_clk_i;
  ext_irq_source src_u (.ref_clk_i, .level_i(lv), .pins_o(pins));
  external_pin_interrupts dut_u (.ref_clk_i, .rst_i, .port0_i(pins),
    .reg_addr_i(ad), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
    .vector_a_i(va), .vector_b_i(vb), .reg_rdata_o(rdat),
    .ext_irq_a_o(ia), .ext_irq_b_o(ib));
  task cmp(input [39:0] n, input [7:0] e, input [7:0] s);
  begin
    checked = checked + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  end
  endtask
  // One register access, strobe over one edge
  task acc(input w, input [7:0] a, input [7:0] d);
  begin
    @(posedge ref_clk_i);
    #1 {wr, rd, ad, wd} = {w, !w, a, d};
    @(posedge ref_clk_i);
    #1 {wr, rd} = 2'b00;
  end
  endtask
  task finish_test;
  begin
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // Watchdog
  initial
  begin
    #100000 fail_count = fail_count + 1;
    finish_test;
  end
  // Rows: config, pins, expected a and b
  initial
  begin
    rows[0] = {8'h01, 8'h00, 2'b11};
    rows[1] = {8'h01, 8'h03, 2'b00};
    rows[2] = {8'hf8, 8'h80, 2'b01};
    rows[3] = {8'h3d, 8'h28, 2'b10};
    repeat (8) @(posedge ref_clk_i);
    #1 rst_i = 0;
    acc(0, 8'he4, 8'h00);
    cmp("cfg", 8'h01, rdat);
    for (i = 0; i < 4; i = i + 1)
    begin
      acc(1, 8'he4, rows[i][17:10]);
      lv = rows[i][9:2];
      repeat (6) @(posedge ref_clk_i);
      #1 cmp("lvl", {6'h0, rows[i][1:0]}, {6'h0, ia, ib});
    end
    acc(0, 8'h88, 8'h00);
    cmp("timer_control_reg", 8'h02, rdat);
    acc(0, 8'h55, 8'h00);
    cmp("unmap", 8'h00, rdat);
    lv = 8'h00;
    acc(1, 8'h88, 8'h05);
    repeat (6) @(posedge ref_clk_i);
    #1 lv = 8'h20;
    repeat (6) @(posedge ref_clk_i);
    #1 cmp("edge", 8'h01, {7'h0, ia});
    #1 lv = 8'h00;
    repeat (6) @(posedge ref_clk_i);
    #1 cmp("hold", 8'h01, {7'h0, ia});
    #1 va = 1;
    @(posedge ref_clk_i);
    #1 va = 0;
    repeat (3) @(posedge ref_clk_i);
    #1 cmp("vect", 8'h00, {7'h0, ia});
    cmp("edgeb", 8'h01, {7'h0, ib});
    #1 vb = 1;
    @(posedge ref_clk_i);
    #1 vb = 0;
    repeat (3) @(posedge ref_clk_i);
    #1 cmp("vectb", 8'h00, {7'h0, ib});
    acc(0, 8'h88, 8'h00);
    cmp("timer_control_reg", 8'h05, rdat);
    // Reset in mid-run, then level flags and config again
    #1 rst_i = 1;
    repeat (2) @(posedge ref_clk_i);
    #1 cmp("rsti", 8'h00, {6'h0, ia, ib});
    cmp("rstr", 8'h00, rdat);
    rst_i = 0;
    repeat (8) @(posedge ref_clk_i);
    #1 cmp("lvlr", 8'h03, {6'h0, ia, ib});
    acc(0, 8'he4, 8'h00);
    cmp("cfgr", 8'h01, rdat);
    finish_test;
  end
endmodule // external_pin_interrupts_tb_top
